// ---- hw/adc_slice_pkg.sv ----
/*
  Constants, register indices, field positions and carrier types for the converter
  control slice.
  Assumes a 10 MHz reference clock, one synchronous active-high reset, and software
  access over AXI4-Lite.
*/
// What this block does
// - Single-ended uses positive select only; differential uses positive and negative.
// - Selection fields pass a holding register; idle selection tracks writes continuously.
// - A started conversion freezes the active selection against later writes.
// - Tracking resumes in the last converter-clock cycle before completion.
// - Start command begins conversion at the next converter-clock rising edge.
// - One positive select code routes the temperature sensor to the converter.
// - Differential 32, 64, 128 samples at 12-bit (only 128 at 10-bit) fill 16 bits truncated, ignoring left adjust.
// - A matching result sets the window flag and requests its interrupt.
// - Four conditions: below low, above high, strictly inside, outside.
// - Thresholds from low/high registers; condition from control five mode field.
// - With accumulation compare only after the last sample, once per accumulation.
// - Comparison uses the full accumulated result, never single samples.
// - Valid non-zero mode code enables the comparator; zero disables it.
// - Left adjust keeps the MSB at bit 15 for every accumulation count.
// - Over 16 samples at 12-bit (over 64 at 10-bit), low sum bits are dropped to fit 16 bits.
// - Result right-adjusted by default; left adjust puts top bits high.
// - Interrupt asserted while flag and enable set, until the flag clears.
package adc_slice_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int          AXI_ADDR_W   = 8;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [5:0]  IDX_CTRL_A   = 6'h00;
  localparam logic [5:0]  IDX_CTRL_B   = 6'h01;
  localparam logic [5:0]  IDX_CTRL_E   = 6'h04;
  localparam logic [5:0]  IDX_POS_SEL  = 6'h08;
  localparam logic [5:0]  IDX_NEG_SEL  = 6'h09;
  localparam logic [5:0]  IDX_COMMAND  = 6'h0A;
  localparam logic [5:0]  IDX_INT_EN   = 6'h0C;
  localparam logic [5:0]  IDX_INT_FLAG = 6'h0D;
  localparam logic [5:0]  IDX_RESULT   = 6'h10;
  localparam logic [5:0]  IDX_WIN_LO   = 6'h12;
  localparam logic [5:0]  IDX_WIN_HI   = 6'h14;

  // ----------------------------------------------------------------
  // Field positions, masks and codes
  // ----------------------------------------------------------------
  localparam int          CTRLA_ENABLE  = 0;
  localparam int          CTRLA_FREERUN = 1;
  localparam int          CTRLA_RES10   = 2;
  localparam int          CTRLA_LEFT_ADJUST_RESULT = 4;
  localparam int          CTRLA_DIFF    = 5;
  localparam int          CMD_START     = 0;
  localparam int          FLAG_RESULT_READY_FLAG   = 0;
  localparam int          FLAG_WINDOW_COMPARE_FLAG     = 1;
  localparam logic [7:0]  MASK_CTRL_A   = 8'hBF;
  localparam logic [7:0]  MASK_3BIT     = 8'h07;
  localparam logic [7:0]  MASK_SEL      = 8'h7F;
  localparam logic [7:0]  MASK_INT      = 8'h03;
  localparam logic [6:0]  SEL_TEMP_SENSE = 7'h42;
  localparam logic [6:0]  SEL_NEG_NONE   = 7'h00;
  localparam logic [2:0]  WIN_OFF       = 3'h0;
  localparam logic [2:0]  WIN_BELOW     = 3'h1;
  localparam logic [2:0]  WIN_ABOVE     = 3'h2;
  localparam logic [2:0]  WIN_INSIDE    = 3'h3;
  localparam logic [2:0]  WIN_OUTSIDE   = 3'h4;
  localparam logic [4:0]  BITS_12       = 5'h0C;
  localparam logic [4:0]  BITS_10       = 5'h0A;
  localparam logic [4:0]  BITS_RESULT   = 5'h10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          REF_CLK_HZ   = 10_000_000;
  localparam int          ADC_CLK_HZ   = 2_500_000;
  localparam int          ADC_DIV      = (REF_CLK_HZ + ADC_CLK_HZ - 1) / ADC_CLK_HZ;
  localparam logic [3:0]  ADC_DIV_LAST = 4'(ADC_DIV - 1);
  localparam logic [3:0]  SAMPLE_LAST  = 4'hE;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  ctrl_e;
    logic [7:0]  pos_sel;
    logic [7:0]  neg_sel;
    logic [7:0]  int_en;
    logic        start_cmd;
    logic [1:0]  flags;
    logic [15:0] result;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
  } regs_t;

  typedef struct packed {
    logic                  aw_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  awready;
    logic                  wready;
    logic                  arready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } axi_t;

endpackage : adc_slice_pkg

// ---- hw/adc_slice_top.sv ----
/*
  Converter control slice: AXI4-Lite register file, channel selection holding and
  locking, conversion sequencing on a divided converter clock, accumulation,
  result formatting and the window comparator with its flags.
  Assumes the analog core returns each sample on I_SAMPLE_DATA, right-justified at
  the chosen resolution, on this same clock, and holds it during the last
  converter-clock cycle of each sample.
*/
`timescale 1ns/1ns
module adc_slice_top
  import adc_slice_pkg::*;
(
  input  wire logic                  I_REF_CLK,
  input  wire logic                  I_RESET,
  input  wire logic                  I_CLK_EN,
  input  wire logic                  I_AWVALID,
  output logic                       O_AWREADY,
  input  wire logic [AXI_ADDR_W-1:0] I_AWADDR,
  input  wire logic [2:0]            I_AWPROT,
  input  wire logic                  I_WVALID,
  output logic                       O_WREADY,
  input  wire logic [31:0]           I_WDATA,
  input  wire logic [3:0]            I_WSTRB,
  output logic                       O_BVALID,
  input  wire logic                  I_BREADY,
  output logic [1:0]                 O_BRESP,
  input  wire logic                  I_ARVALID,
  output logic                       O_ARREADY,
  input  wire logic [AXI_ADDR_W-1:0] I_ARADDR,
  input  wire logic [2:0]            I_ARPROT,
  output logic                       O_RVALID,
  input  wire logic                  I_RREADY,
  output logic [31:0]                O_RDATA,
  output logic [1:0]                 O_RRESP,
  input  wire logic [11:0]           I_SAMPLE_DATA,
  output logic [6:0]                 O_POS_SEL,
  output logic [6:0]                 O_NEG_SEL,
  output logic                       O_DIFF_MODE,
  output logic                       O_TEMP_SENSE_EN,
  output logic                       O_CONV_BUSY,
  output logic                       O_ADC_CLK_TICK,
  output logic                       O_RESULT_READY_FLAG_IRQ,
  output logic                       O_WINDOW_COMPARE_FLAG_IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    axi_t        axi;
    regs_t       regs;
    conv_state_t conv;
    logic [3:0]  div;
    logic [3:0]  tick_cnt;
    logic [6:0]  samp_cnt;
    logic [19:0] acc;
    logic [6:0]  pos_act;
    logic [6:0]  neg_act;
    logic        diff_act;
    logic        temp_en;
    logic        tick_out;
    logic        result_ready_flag_irq;
    logic        window_compare_flag_irq;
  } state_t;

  state_t q;
  state_t d;

  logic [19:0] sample_ext;
  logic [19:0] acc_sum;
  logic [15:0] new_result;
  logic        win_hit;
  logic        cfg_diff;
  logic        cfg_res10;
  logic [2:0]  cfg_accum;

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  function automatic logic [15:0] fmt_result(input logic [19:0] sum,
                                             input logic [2:0]  k,
                                             input logic        diff,
                                             input logic        res10,
                                             input logic        ladj);
    logic [4:0]  w;
    logic [4:0]  tr;
    logic [4:0]  ls;
    logic [19:0] t;
    w  = (res10 ? BITS_10 : BITS_12) + {2'h0, k};
    tr = (w > BITS_RESULT) ? 5'(w - BITS_RESULT) : 5'h00;
    ls = (ladj && (w < BITS_RESULT)) ? 5'(BITS_RESULT - w) : 5'h00;
    t  = diff ? 20'($signed(sum) >>> tr) : (sum >> tr);
    return 16'(t[15:0] << ls);
  endfunction : fmt_result

  // Merges a 16-bit write under the byte strobes.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [31:0] read_mux(input regs_t r, input logic [5:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      IDX_CTRL_A:   v[7:0]  = r.ctrl_a;
      IDX_CTRL_B:   v[7:0]  = r.ctrl_b;
      IDX_CTRL_E:   v[7:0]  = r.ctrl_e;
      IDX_POS_SEL:  v[7:0]  = r.pos_sel;
      IDX_NEG_SEL:  v[7:0]  = r.neg_sel;
      IDX_COMMAND:  v[CMD_START] = r.start_cmd;
      IDX_INT_EN:   v[7:0]  = r.int_en;
      IDX_INT_FLAG: v[1:0]  = r.flags;
      IDX_RESULT:   v[15:0] = r.result;
      IDX_WIN_LO:   v[15:0] = r.win_lo;
      IDX_WIN_HI:   v[15:0] = r.win_hi;
      default:      v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_mux

  function automatic logic mapped(input logic [5:0] idx);
    return idx inside {IDX_CTRL_A, IDX_CTRL_B, IDX_CTRL_E, IDX_POS_SEL, IDX_NEG_SEL,
                       IDX_COMMAND, IDX_INT_EN, IDX_INT_FLAG, IDX_RESULT, IDX_WIN_LO,
                       IDX_WIN_HI};
  endfunction : mapped

  // ----------------------------------------------------------------
  // Datapath and comparator
  // ----------------------------------------------------------------
  assign cfg_diff   = q.regs.ctrl_a[CTRLA_DIFF];
  assign cfg_res10  = q.regs.ctrl_a[CTRLA_RES10];
  assign cfg_accum  = q.regs.ctrl_b[2:0];
  assign sample_ext = cfg_res10 ? {{10{I_SAMPLE_DATA[9] & cfg_diff}}, I_SAMPLE_DATA[9:0]}
                                : {{8{I_SAMPLE_DATA[11] & cfg_diff}}, I_SAMPLE_DATA};
  assign acc_sum    = 20'(q.acc + sample_ext);
  assign new_result = fmt_result(acc_sum, cfg_accum, cfg_diff, cfg_res10,
                                 q.regs.ctrl_a[CTRLA_LEFT_ADJUST_RESULT]);

  adc_window_cmp u_cmp (
    .i_result (new_result),
    .i_signed (cfg_diff),
    .i_low    (q.regs.win_lo),
    .i_high   (q.regs.win_hi),
    .i_mode   (q.regs.ctrl_e[2:0]),
    .o_hit    (win_hit)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       tick;
    logic       last_tick;
    logic       last_samp;
    logic       track;
    logic [5:0] widx;
    d         = q;
    track     = 1'b0;
    tick      = (q.div == ADC_DIV_LAST);
    last_tick = (q.tick_cnt == SAMPLE_LAST);
    last_samp = (q.samp_cnt == 7'((8'h01 << cfg_accum) - 8'h01));
    widx      = q.axi.aw_addr[7:2];
    d.div     = tick ? 4'h0 : 4'(q.div + 4'h1);
    d.tick_out = tick;

    // Bus write channel.
    if (I_AWVALID && q.axi.awready) begin
      d.axi.aw_held = 1'b1;
      d.axi.aw_addr = I_AWADDR;
    end
    if (I_WVALID && q.axi.wready) begin
      d.axi.w_held = 1'b1;
      d.axi.w_data = I_WDATA;
      d.axi.w_strb = I_WSTRB;
    end
    if (q.axi.bvalid && I_BREADY) begin
      d.axi.bvalid = 1'b0;
    end
    if (q.axi.aw_held && q.axi.w_held && !q.axi.bvalid) begin
      d.axi.aw_held = 1'b0;
      d.axi.w_held  = 1'b0;
      d.axi.bvalid  = 1'b1;
      d.axi.bresp   = mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      if (q.axi.w_strb[0]) begin
        unique case (widx)
          IDX_CTRL_A:   d.regs.ctrl_a  = q.axi.w_data[7:0] & MASK_CTRL_A;
          IDX_CTRL_B:   d.regs.ctrl_b  = q.axi.w_data[7:0] & MASK_3BIT;
          IDX_CTRL_E:   d.regs.ctrl_e  = q.axi.w_data[7:0] & MASK_3BIT;
          IDX_POS_SEL:  d.regs.pos_sel = q.axi.w_data[7:0] & MASK_SEL;
          IDX_NEG_SEL:  d.regs.neg_sel = q.axi.w_data[7:0] & MASK_SEL;
          IDX_COMMAND:  d.regs.start_cmd = q.regs.start_cmd | q.axi.w_data[CMD_START];
          IDX_INT_EN:   d.regs.int_en  = q.axi.w_data[7:0] & MASK_INT;
          IDX_INT_FLAG: d.regs.flags   = q.regs.flags & ~q.axi.w_data[1:0];
          default:      d.regs = d.regs;
        endcase
      end
      unique case (widx)
        IDX_WIN_LO: d.regs.win_lo = merge16(q.regs.win_lo, q.axi.w_data, q.axi.w_strb);
        IDX_WIN_HI: d.regs.win_hi = merge16(q.regs.win_hi, q.axi.w_data, q.axi.w_strb);
        default:    d.regs = d.regs;
      endcase
    end

    // Bus read channel.
    if (q.axi.rvalid && I_RREADY) begin
      d.axi.rvalid = 1'b0;
    end
    if (I_ARVALID && q.axi.arready) begin
      d.axi.rvalid = 1'b1;
      d.axi.rdata  = read_mux(q.regs, I_ARADDR[7:2]);
      d.axi.rresp  = mapped(I_ARADDR[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end

    // Conversion sequencing on the converter clock.
    unique case (q.conv)
      CONV_IDLE: begin
        track = 1'b1;
        if (tick && q.regs.start_cmd && q.regs.ctrl_a[CTRLA_ENABLE]) begin
          d.conv     = CONV_RUN;
          d.tick_cnt = 4'h0;
          d.samp_cnt = 7'h00;
          d.acc      = 20'h0_0000;
        end
      end
      CONV_RUN: begin
        track = last_samp && last_tick;
        if (tick) begin
          if (last_tick) begin
            d.tick_cnt = 4'h0;
            d.acc      = acc_sum;
            d.samp_cnt = 7'(q.samp_cnt + 7'h01);
            if (last_samp) begin
              d.conv = CONV_IDLE;
              d.regs.result = new_result;
              d.regs.flags[FLAG_RESULT_READY_FLAG] = 1'b1;
              if (win_hit) begin
                d.regs.flags[FLAG_WINDOW_COMPARE_FLAG] = 1'b1;
              end
              if (!q.regs.ctrl_a[CTRLA_FREERUN]) begin
                d.regs.start_cmd = 1'b0;
              end
            end
          end else begin
            d.tick_cnt = 4'(q.tick_cnt + 4'h1);
          end
        end
      end
    endcase

    if (!q.regs.ctrl_a[CTRLA_ENABLE]) begin
      d.conv = CONV_IDLE;
    end

    if (track) begin
      d.pos_act  = d.regs.pos_sel[6:0];
      d.diff_act = d.regs.ctrl_a[CTRLA_DIFF];
      d.neg_act  = d.regs.ctrl_a[CTRLA_DIFF] ? d.regs.neg_sel[6:0] : SEL_NEG_NONE;
    end

    d.temp_en     = (d.pos_act == SEL_TEMP_SENSE);
    d.result_ready_flag_irq  = d.regs.flags[FLAG_RESULT_READY_FLAG] & d.regs.int_en[FLAG_RESULT_READY_FLAG];
    d.window_compare_flag_irq    = d.regs.flags[FLAG_WINDOW_COMPARE_FLAG] & d.regs.int_en[FLAG_WINDOW_COMPARE_FLAG];
    d.axi.awready = !d.axi.aw_held && !d.axi.bvalid;
    d.axi.wready  = !d.axi.w_held && !d.axi.bvalid;
    d.axi.arready = !d.axi.rvalid;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      q <= '0;
    end else if (I_CLK_EN) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_AWREADY       = q.axi.awready;
  assign O_WREADY        = q.axi.wready;
  assign O_BVALID        = q.axi.bvalid;
  assign O_BRESP         = q.axi.bresp;
  assign O_ARREADY       = q.axi.arready;
  assign O_RVALID        = q.axi.rvalid;
  assign O_RDATA         = q.axi.rdata;
  assign O_RRESP         = q.axi.rresp;
  assign O_POS_SEL       = q.pos_act;
  assign O_NEG_SEL       = q.neg_act;
  assign O_DIFF_MODE     = q.diff_act;
  assign O_TEMP_SENSE_EN = q.temp_en;
  assign O_CONV_BUSY     = (q.conv == CONV_RUN);
  assign O_ADC_CLK_TICK  = q.tick_out;
  assign O_RESULT_READY_FLAG_IRQ    = q.result_ready_flag_irq;
  assign O_WINDOW_COMPARE_FLAG_IRQ      = q.window_compare_flag_irq;

endmodule : adc_slice_top

// ---- hw/adc_window_cmp.sv ----
/*
  Window comparator: tests one result against the low and high thresholds.
  Assumes the caller presents a stable result and registers the hit.
*/
`timescale 1ns/1ns
module adc_window_cmp
  import adc_slice_pkg::*;
(
  input  wire logic [15:0] i_result,
  input  wire logic        i_signed,
  input  wire logic [15:0] i_low,
  input  wire logic [15:0] i_high,
  input  wire logic [2:0]  i_mode,
  output logic             o_hit
);

  logic below;
  logic above;

  always_comb begin
    if (i_signed) begin
      below = $signed(i_result) < $signed(i_low);
      above = $signed(i_result) > $signed(i_high);
    end else begin
      below = i_result < i_low;
      above = i_result > i_high;
    end
    case (i_mode)
      WIN_BELOW:   o_hit = below;
      WIN_ABOVE:   o_hit = above;
      WIN_INSIDE:  o_hit = !below && !above && (i_result != i_low) && (i_result != i_high);
      WIN_OUTSIDE: o_hit = below || above;
      default:     o_hit = 1'b0;
    endcase
  end

endmodule : adc_window_cmp

// ---- sim/adc_slice_checker.sv ----
/*
  Port checker for the converter control slice.
  Assumes it is bound into adc_slice_top and that the reset is synchronous, high.
*/
`timescale 1ns/1ns
module adc_slice_checker
  import adc_slice_pkg::*;
(
  input wire logic        I_REF_CLK,
  input wire logic        I_RESET,
  input wire logic        I_BREADY,
  input wire logic        I_RREADY,
  input wire logic        O_BVALID,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_RVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic [6:0]  O_POS_SEL,
  input wire logic [6:0]  O_NEG_SEL,
  input wire logic        O_DIFF_MODE,
  input wire logic        O_TEMP_SENSE_EN,
  input wire logic        O_CONV_BUSY,
  input wire logic        O_ADC_CLK_TICK,
  input wire logic        O_RESULT_READY_FLAG_IRQ,
  input wire logic        O_WINDOW_COMPARE_FLAG_IRQ
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_busy8; O_CONV_BUSY [*8]; endsequence
  sequence s_done; !O_CONV_BUSY && $past(O_CONV_BUSY); endsequence
  property p_tick; O_ADC_CLK_TICK |=> !O_ADC_CLK_TICK [*3] ##1 O_ADC_CLK_TICK; endproperty
  property p_lock; s_busy8 |-> $past(O_POS_SEL, 6) == $past(O_POS_SEL, 5) &&
    $past(O_NEG_SEL, 6) == $past(O_NEG_SEL, 5) && $past(O_DIFF_MODE, 6) == $past(O_DIFF_MODE, 5);
  endproperty
  property p_temp; O_TEMP_SENSE_EN == (O_POS_SEL == SEL_TEMP_SENSE); endproperty
  property p_single; !O_DIFF_MODE |-> O_NEG_SEL == SEL_NEG_NONE; endproperty
  property p_irq_hold; $fell(O_WINDOW_COMPARE_FLAG_IRQ) |-> O_BVALID; endproperty
  property p_window_compare_flag_end; $rose(O_WINDOW_COMPARE_FLAG_IRQ) |-> O_BVALID or s_done; endproperty
  property p_window_compare_flag_ready; $rose(O_WINDOW_COMPARE_FLAG_IRQ) && !O_BVALID |-> O_RESULT_READY_FLAG_IRQ; endproperty
  property p_bhold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
  property p_rhold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_tick: assert property (p_tick) else $error("converter tick spacing wrong");
  a_lock: assert property (p_lock) else $error("selection moved mid conversion");
  a_temp: assert property (p_temp) else $error("temperature route decode wrong");
  a_single: assert property (p_single) else $error("negative select used");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unasked");
  a_window_compare_flag_end: assert property (p_window_compare_flag_end) else $error("window irq mid conversion");
  a_window_compare_flag_ready: assert property (p_window_compare_flag_ready) else $error("window flag apart from ready");
  a_bhold: assert property (p_bhold) else $error("write response not held");
  a_rhold: assert property (p_rhold) else $error("read data not held");
endmodule : adc_slice_checker

bind adc_slice_top adc_slice_checker i_adc_slice_checker (
  .I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_BREADY(I_BREADY), .I_RREADY(I_RREADY),
  .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA),
  .O_POS_SEL(O_POS_SEL), .O_NEG_SEL(O_NEG_SEL), .O_DIFF_MODE(O_DIFF_MODE),
  .O_TEMP_SENSE_EN(O_TEMP_SENSE_EN), .O_CONV_BUSY(O_CONV_BUSY),
  .O_ADC_CLK_TICK(O_ADC_CLK_TICK), .O_RESULT_READY_FLAG_IRQ(O_RESULT_READY_FLAG_IRQ), .O_WINDOW_COMPARE_FLAG_IRQ(O_WINDOW_COMPARE_FLAG_IRQ));

// ---- sim/tb_top.sv ----
/*
  Self-checking bench for the converter control slice.
  Assumes the bench plays both software on AXI4-Lite and the analog sample source.
*/
`timescale 1ns/1ns
module tb_top;
  import adc_slice_pkg::*;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [11:0] sample = 0;
  logic [1:0]  bresp, rresp;
  logic [6:0]  pos_sel, neg_sel;
  logic awready, wready, bvalid, arready, rvalid, diff_mode, temp_en, busy, tick, rirq, wirq;
  int error_cnt = 0, n_compared = 0;
  localparam logic [11:0] SV [4] = '{12'h080, 12'h100, 12'h180, 12'h280};
  always #50 clk = ~clk;
  adc_slice_top i_adc_slice_top (.I_REF_CLK(clk), .I_RESET(rst), .I_CLK_EN(1'b1),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr), .I_AWPROT(3'h0),
    .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(4'hF),
    .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .I_ARADDR(araddr), .I_ARPROT(3'h0), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_SAMPLE_DATA(sample),
    .O_POS_SEL(pos_sel), .O_NEG_SEL(neg_sel), .O_DIFF_MODE(diff_mode),
    .O_TEMP_SENSE_EN(temp_en), .O_CONV_BUSY(busy), .O_ADC_CLK_TICK(tick),
    .O_RESULT_READY_FLAG_IRQ(rirq), .O_WINDOW_COMPARE_FLAG_IRQ(wirq));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task report_and_stop();
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task hang(input string nm);
    $display("ERROR %s expected done seen timeout", nm);
    error_cnt++;
    report_and_stop();
  endtask : hang
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic axi_wr(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (n >= 100) hang("write");
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(idx, d, r);
  endtask : wr
  task automatic rd(input logic [5:0] idx, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (n >= 100) hang("read");
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic start_conv();
    int n;
    wr(IDX_COMMAND, 32'h1);
    for (n = 0; busy !== 1'b1 && n < 12; n++) @(posedge clk);
    if (n >= 12) hang("start");
  endtask : start_conv
  task automatic wait_done();
    int n;
    for (n = 0; busy !== 1'b0 && n < 9000; n++) @(posedge clk);
    if (n >= 9000) hang("conversion");
  endtask : wait_done
  task automatic cfg(input logic [11:0] s, input int k, input logic d, input logic l);
    sample <= s;
    wr(IDX_CTRL_A, 32'h1 | (32'(d) << CTRLA_DIFF) | (32'(l) << CTRLA_LEFT_ADJUST_RESULT));
    wr(IDX_CTRL_B, 32'(k));
  endtask : cfg
  function automatic logic [15:0] exp_res(logic [11:0] s, int k, logic d, logic l);
    logic signed [23:0] v;
    int w;
    v = d ? 24'(signed'(s)) : {12'h0, s};
    v = v <<< k;
    w = 12 + k;
    if (w > 16) return 16'(v >>> (w - 16));
    if (l) return 16'(v << (16 - w));
    return 16'(v);
  endfunction : exp_res
  function automatic logic win_hit(logic [15:0] r, logic d, logic [2:0] m);
    int rv;
    rv = d ? int'($signed(r)) : int'(r);
    case (m)
      WIN_BELOW: return rv < 256;
      WIN_ABOVE: return rv > 512;
      WIN_INSIDE: return rv > 256 && rv < 512;
      WIN_OUTSIDE: return rv < 256 || rv > 512;
      default: return 1'b0;
    endcase
  endfunction : win_hit
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] v;
    logic [1:0]  r;
    rd(IDX_CTRL_A, v, r);
    chk("ctrl_a reset", 32'h0, v);
    axi_wr(IDX_RESULT, 32'hFFFF, r);
    rd(IDX_RESULT, v, r);
    chk("result read only", 32'h0, v);
    rd(6'h3F, v, r);
    chk("unmapped read resp", 32'(RESP_SLVERR), 32'(r));
    axi_wr(6'h3F, 32'h1, r);
    chk("unmapped write resp", 32'(RESP_SLVERR), 32'(r));
  endtask : t_regs
  task automatic fmt(input logic [11:0] s, input int k, input logic d, input logic l);
    logic [31:0] v;
    logic [1:0]  r;
    cfg(s, k, d, l);
    start_conv();
    wait_done();
    rd(IDX_RESULT, v, r);
    chk("result", {16'h0, exp_res(s, k, d, l)}, v);
  endtask : fmt
  task automatic win(input logic [11:0] s, input int k, input logic d, input logic [2:0] m);
    logic [31:0] v;
    logic [1:0]  r;
    logic        h;
    cfg(s, k, d, 1'b0);
    wr(IDX_CTRL_E, 32'(m));
    start_conv();
    wait_done();
    h = win_hit(exp_res(s, k, d, 1'b0), d, m);
    rd(IDX_INT_FLAG, v, r);
    chk("window flag", {30'h0, h, 1'b1}, v);
    chk("window irq", 32'(h), 32'(wirq));
    chk("ready irq", 32'h1, 32'(rirq));
    wr(IDX_INT_FLAG, 32'h3);
    @(posedge clk);
    chk("window irq cleared", 32'h0, 32'(wirq));
  endtask : win
  task automatic t_lock();
    int n;
    wr(IDX_POS_SEL, 32'h05);
    wr(IDX_NEG_SEL, 32'h03);
    cfg(12'h010, 1, 1'b1, 1'b0);
    chk("idle track", 32'h05, 32'(pos_sel));
    start_conv();
    wr(IDX_POS_SEL, 32'(SEL_TEMP_SENSE));
    chk("locked pos", 32'h05, 32'(pos_sel));
    chk("diff neg", 32'h03, 32'(neg_sel));
    for (n = 0; pos_sel !== SEL_TEMP_SENSE && n < 200; n++) @(posedge clk);
    if (n >= 200) hang("resume");
    chk("busy at resume", 32'h1, 32'(busy));
    wait_done();
    chk("resumed pos", 32'(SEL_TEMP_SENSE), 32'(pos_sel));
    chk("temp route", 32'h1, 32'(temp_en));
    cfg(12'h010, 0, 1'b0, 1'b0);
    chk("single neg", 32'h0, 32'(neg_sel));
  endtask : t_lock
  task automatic t_res10();
    logic [31:0] v;
    logic [1:0]  r;
    sample <= 12'hAAB;
    wr(IDX_CTRL_A, 32'h15);
    wr(IDX_CTRL_B, 32'h0);
    start_conv();
    wait_done();
    rd(IDX_RESULT, v, r);
    chk("10-bit left adjust", 32'hAAC0, v);
  endtask : t_res10
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_lock();
    fmt(12'h123, 0, 1'b0, 1'b0);
    fmt(12'h123, 0, 1'b0, 1'b1);
    fmt(12'hABC, 2, 1'b0, 1'b1);
    fmt(12'hFFF, 5, 1'b0, 1'b0);
    fmt(12'h801, 5, 1'b1, 1'b1);
    fmt(12'hFFF, 7, 1'b1, 1'b0);
    fmt(12'h800, 1, 1'b1, 1'b0);
    t_res10();
    wr(IDX_WIN_LO, 32'h0100);
    wr(IDX_WIN_HI, 32'h0200);
    wr(IDX_INT_EN, 32'h3);
    for (int m = 0; m < 5; m++) begin
      for (int i = 0; i < 4; i++) win(SV[i], 0, 1'b0, 3'(m));
    end
    win(12'h0C0, 1, 1'b0, WIN_INSIDE);
    win(12'hFFF, 0, 1'b1, WIN_BELOW);
    report_and_stop();
  end
endmodule : tb_top
